// ### logic/mds_supervisor.sv
// Purpose: Supervisory control of a standalone brushed DC motor drive.
// Assumes: Single clock, synchronous reset at power-on, digital fault flags.
// Notes:
`timescale 1ns/1ps
module mds_supervisor #(
    parameter int POWERUP_TIME = mds_pkg::POWERUP_CYCLES,
    parameter int STANDBY_TIME = mds_pkg::STANDBY_CYCLES,
    parameter int STALL_TIME = mds_pkg::STALL_CYCLES,
    parameter int INVTIME_TIME = mds_pkg::INVTIME_MAX_CYCLES,
    parameter int DEBOUNCE_TIME = mds_pkg::DEBOUNCE_CYCLES,
    parameter int BLINK_TIME = mds_pkg::BLINK_CYCLES,
    parameter int PAUSE_TIME = mds_pkg::PAUSE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Control pins, asynchronous
    input wire logic run_stop_n,
    input wire logic direction_select_input,
    input wire logic speed_set_n,
    // Measurement flags, synchronous
    input wire mds_pkg::mds_fault_type faults,
    input wire logic [7:0] current_level,
    input wire logic acquisition_done,
    // Register bus
    input wire mds_pkg::mds_axi_req_type axi_req,
    output mds_pkg::mds_axi_rsp_type axi_rsp,
    // Drive and status
    output mds_pkg::mds_drive_type drive,
    output logic [2:0] alarm_number,
    // Open collector indicator
    output logic open_collector_indicator,
    output logic open_collector_indicator_oe_n
);
    import mds_pkg::*;

    localparam int TIMER_MAX = (STANDBY_TIME > POWERUP_TIME) ? STANDBY_TIME : POWERUP_TIME;
    localparam int TIMER_W = $clog2(TIMER_MAX + 1);
    localparam int STALL_W = $clog2(STALL_TIME + 1);
    localparam int DEB_W = $clog2(DEBOUNCE_TIME + 1);
    localparam int BLINK_MAX = (PAUSE_TIME > BLINK_TIME) ? PAUSE_TIME : BLINK_TIME;
    localparam int BLINK_W = $clog2(BLINK_MAX + 1);
    localparam logic [39:0] INV_LIMIT = 40'(INVTIME_TIME) << INV_SHIFT;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0][DEB_W-1:0] deb_cnt;
        logic [2:0] deb;
        mds_state_type st;
        logic [TIMER_W-1:0] timer;
        logic [STALL_W-1:0] stall_cnt;
        logic [39:0] inv_acc;
        logic acquire_pending;
        logic [2:0] alarm;
        logic [1:0] control;
        logic [BLINK_W-1:0] blink_timer;
        logic [2:0] blink_count;
        logic blink_on;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        mds_axi_rsp_type rsp;
        mds_drive_type drive;
        logic indicator_oe_n;
    } mds_regs_type;

    mds_regs_type s;
    mds_regs_type next_s;
    logic start;
    logic active;
    logic stall_trip;
    logic inv_trip;
    logic [2:0] detected;
    logic [31:0] status_word;

    always_comb begin
        next_s = s;
        // Second flop alone reads the first
        next_s.sync1 = {speed_set_n, direction_select_input, run_stop_n};
        next_s.sync2 = s.sync1;
        for (int i = 0; i < 3; i++) begin
            if (s.sync2[i] == s.deb[i]) begin
                next_s.deb_cnt[i] = '0;
            end else if (s.deb_cnt[i] == DEB_W'(DEBOUNCE_TIME - 1)) begin
                next_s.deb[i] = s.sync2[i];
                next_s.deb_cnt[i] = '0;
            end else begin
                next_s.deb_cnt[i] = s.deb_cnt[i] + 1'b1;
            end
        end

        start = !s.deb[IN_RUN];
        active = (s.st == MDS_RUN) || (s.st == MDS_ACQUIRE);

        // Stall: counter parks at its limit while current stays above stall
        if (active && faults.over_stall) begin
            if (s.stall_cnt != STALL_W'(STALL_TIME)) begin
                next_s.stall_cnt = s.stall_cnt + 1'b1;
            end
        end else begin
            next_s.stall_cnt = '0;
        end
        stall_trip = faults.over_stall && (s.stall_cnt == STALL_W'(STALL_TIME));

        // Higher level adds faster, so the delay falls from 10 s toward 5 s
        if (active && faults.over_max_power) begin
            next_s.inv_acc = s.inv_acc + 40'(INV_BASE) + 40'(current_level);
        end else begin
            next_s.inv_acc = '0;
        end
        inv_trip = s.inv_acc >= INV_LIMIT;

        // Lowest number wins when several arrive in one cycle
        detected = ALARM_NONE;
        if (s.st != MDS_POWERUP) begin
            if (faults.undervoltage) begin
                detected = ALARM_UNDERVOLTAGE;
            end else if (faults.overvoltage) begin
                detected = ALARM_OVERVOLTAGE;
            end else if (active && (inv_trip || stall_trip)) begin
                detected = ALARM_OVERCURRENT;
            end else if (active && (faults.motor_short || faults.output_stage_fault)) begin
                detected = ALARM_STAGE;
            end
        end

        if (s.timer != '0) begin
            next_s.timer = s.timer - 1'b1;
        end

        if (s.alarm == ALARM_NONE && detected != ALARM_NONE) begin
            next_s.alarm = detected;
            next_s.st = MDS_FAULT;
        end else begin
            unique case (s.st)
                MDS_POWERUP: begin
                    if (s.timer == '0) begin
                        if (start) begin
                            next_s.alarm = ALARM_INVALID_START;
                            next_s.st = MDS_INVALID_START;
                        end else begin
                            next_s.st = MDS_SLEEP;
                        end
                    end
                end
                MDS_INVALID_START: begin
                    if (!start) begin
                        next_s.alarm = ALARM_NONE;
                        next_s.st = MDS_SLEEP;
                    end
                end
                MDS_SLEEP: begin
                    if (start) begin
                        next_s.st = s.acquire_pending ? MDS_ACQUIRE : MDS_RUN;
                    end
                end
                MDS_ACQUIRE: begin
                    if (acquisition_done) begin
                        next_s.acquire_pending = 1'b0;
                        next_s.st = MDS_RUN;
                    end else if (!start) begin
                        next_s.st = MDS_STOP_DELAY;
                        next_s.timer = TIMER_W'(STANDBY_TIME - 1);
                    end
                end
                MDS_RUN: begin
                    if (!start) begin
                        next_s.st = MDS_STOP_DELAY;
                        next_s.timer = TIMER_W'(STANDBY_TIME - 1);
                    end
                end
                MDS_STOP_DELAY: begin
                    if (start) begin
                        next_s.st = s.acquire_pending ? MDS_ACQUIRE : MDS_RUN;
                    end else if (s.timer == '0 && s.control[CTRL_STANDBY_BIT]) begin
                        next_s.st = MDS_SLEEP;
                    end
                end
                MDS_FAULT: begin
                    // Left only through reset, the power-on
                    next_s.st = MDS_FAULT;
                end
            endcase
        end

        next_s.drive.motor_enable = (next_s.st == MDS_RUN) || (next_s.st == MDS_ACQUIRE);
        next_s.drive.motor_reverse = s.deb[IN_DIR];
        next_s.drive.speed_set = !s.deb[IN_SPEED];
        next_s.drive.sleep = next_s.st == MDS_SLEEP;
        next_s.drive.acquire_request = next_s.st == MDS_ACQUIRE;

        // Alarm number as pulses then a pause
        if (!s.control[CTRL_INDICATOR_BIT] || s.alarm == ALARM_NONE) begin
            next_s.blink_timer = '0;
            next_s.blink_count = '0;
            next_s.blink_on = 1'b0;
        end else if (s.blink_timer != '0) begin
            next_s.blink_timer = s.blink_timer - 1'b1;
        end else if (s.blink_on) begin
            next_s.blink_on = 1'b0;
            if (s.blink_count + 3'h1 >= s.alarm) begin
                next_s.blink_count = '0;
                next_s.blink_timer = BLINK_W'(PAUSE_TIME - 1);
            end else begin
                next_s.blink_count = s.blink_count + 3'h1;
                next_s.blink_timer = BLINK_W'(BLINK_TIME - 1);
            end
        end else begin
            next_s.blink_on = 1'b1;
            next_s.blink_timer = BLINK_W'(BLINK_TIME - 1);
        end
        next_s.indicator_oe_n = !next_s.blink_on;

        // Write channel: address and data taken in either order
        if (axi_req.awvalid && s.rsp.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s.rsp.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = axi_req.wdata;
            next_s.wstrb = axi_req.wstrb;
        end
        if (s.rsp.bvalid && axi_req.bready) begin
            next_s.rsp.bvalid = 1'b0;
        end
        if (next_s.aw_got && next_s.w_got && !next_s.rsp.bvalid) begin
            next_s.rsp.bresp = RESP_OKAY;
            if (next_s.awaddr == ADDR_CONTROL) begin
                if (next_s.wstrb[0]) begin
                    next_s.control = next_s.wdata[1:0];
                end
            end else if (next_s.awaddr != ADDR_STATUS) begin
                next_s.rsp.bresp = RESP_DECERR;
            end
            next_s.rsp.bvalid = 1'b1;
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
        end
        next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
        next_s.rsp.wready = !next_s.w_got && !next_s.rsp.bvalid;

        status_word = '0;
        status_word[STAT_STATE_LSB +: 3] = s.st;
        status_word[STAT_ALARM_LSB +: 3] = s.alarm;
        status_word[STAT_INPUTS_LSB +: 3] = s.deb;
        status_word[STAT_PENDING_BIT] = s.acquire_pending;

        // Read channel: one read in flight
        if (s.rsp.rvalid && axi_req.rready) begin
            next_s.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s.rsp.arready) begin
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rresp = RESP_OKAY;
            next_s.rsp.rdata = '0;
            if (axi_req.araddr == ADDR_CONTROL) begin
                next_s.rsp.rdata[1:0] = s.control;
            end else if (axi_req.araddr == ADDR_STATUS) begin
                next_s.rsp.rdata = status_word;
            end else begin
                next_s.rsp.rresp = RESP_DECERR;
            end
        end
        next_s.rsp.arready = !next_s.rsp.rvalid;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
            s.sync1 <= INPUTS_IDLE;
            s.sync2 <= INPUTS_IDLE;
            s.deb <= INPUTS_IDLE;
            s.st <= MDS_POWERUP;
            s.timer <= TIMER_W'(POWERUP_TIME - 1);
            s.acquire_pending <= 1'b1;
            s.alarm <= ALARM_NONE;
            s.control <= CONTROL_RESET;
            s.indicator_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign axi_rsp = s.rsp;
    assign drive = s.drive;
    assign alarm_number = s.alarm;
    assign open_collector_indicator = 1'b0;
    assign open_collector_indicator_oe_n = s.indicator_oe_n;

    chk_powerup_quiet: assert property (@(posedge clock) disable iff (reset)
        s.st == MDS_POWERUP |-> !s.drive.motor_enable)
        else $error("drive enabled during power-up wait");
    chk_alarm_stops: assert property (@(posedge clock) disable iff (reset)
        (s.alarm == ALARM_NONE && detected != ALARM_NONE) |=> !s.drive.motor_enable)
        else $error("drive not stopped after alarm");
    chk_latched_alarm: assert property (@(posedge clock) disable iff (reset)
        s.alarm >= ALARM_UNDERVOLTAGE |=> s.alarm == $past(s.alarm) && s.st == MDS_FAULT)
        else $error("latched alarm changed");
    chk_alarm1_clear: assert property (@(posedge clock) disable iff (reset)
        (s.st == MDS_INVALID_START && s.deb[IN_RUN] && detected == ALARM_NONE)
        |=> s.alarm == ALARM_NONE && s.st == MDS_SLEEP)
        else $error("invalid start alarm not cleared on stop");
    chk_undervolt: assert property (@(posedge clock) disable iff (reset)
        (s.st != MDS_POWERUP && faults.undervoltage && s.alarm == ALARM_NONE)
        |=> s.alarm == ALARM_UNDERVOLTAGE)
        else $error("undervoltage not reported as alarm 2");
    chk_stop_delay: assert property (@(posedge clock) disable iff (reset)
        (s.st == MDS_RUN && s.deb[IN_RUN] && detected == ALARM_NONE)
        |=> s.st == MDS_STOP_DELAY ##1 !s.drive.sleep)
        else $error("stop did not start the standby delay");
    chk_stall_trip: assert property (@(posedge clock) disable iff (reset)
        (s.alarm == ALARM_NONE && active && stall_trip && !faults.undervoltage
         && !faults.overvoltage) |=> s.alarm == ALARM_OVERCURRENT ##1 !s.drive.motor_enable)
        else $error("stall beyond limit did not trip alarm 4");
    chk_sleep_entry: assert property (@(posedge clock) disable iff (reset)
        (s.st == MDS_POWERUP && s.timer == '0 && s.deb[IN_RUN] && detected == ALARM_NONE)
        |=> s.st == MDS_SLEEP && s.drive.sleep)
        else $error("power-up at stop did not enter sleep");
    chk_indicator_idle: assert property (@(posedge clock) disable iff (reset)
        s.alarm == ALARM_NONE |=> open_collector_indicator_oe_n)
        else $error("indicator sinking with no alarm");
endmodule : mds_supervisor

// ### include/mds_pkg.sv
// Purpose: Constants, types and register map of the motor drive supervisor.
// Assumes: 50 MHz system clock; AXI4-Lite register access with 32-bit data.
// Notes: Times are given in their own unit; cycle counts are derived here.
package mds_pkg;
    localparam int CLOCK_HZ = 50_000_000;
    localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
    localparam int POWERUP_MS = 200;
    localparam int POWERUP_CYCLES = POWERUP_MS * CYCLES_PER_MS;
    localparam int STANDBY_S = 5;
    localparam int STANDBY_CYCLES = STANDBY_S * CLOCK_HZ;
    localparam int STALL_MS = 500;
    localparam int STALL_CYCLES = STALL_MS * CYCLES_PER_MS;
    localparam int INVTIME_MAX_S = 10;
    localparam int INVTIME_MAX_CYCLES = INVTIME_MAX_S * CLOCK_HZ;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CYCLES_PER_MS;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYCLES = BLINK_MS * CYCLES_PER_MS;
    localparam int PAUSE_MS = 1500;
    localparam int PAUSE_CYCLES = PAUSE_MS * CYCLES_PER_MS;
    // Inverse-time weight: base plus level halves the delay at full level
    localparam int INV_BASE = 256;
    localparam int INV_SHIFT = 8;

    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_INDICATOR_BIT = 0;
    localparam int CTRL_STANDBY_BIT = 1;
    localparam logic [1:0] CONTROL_RESET = 2'h3;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_ALARM_LSB = 4;
    localparam int STAT_INPUTS_LSB = 8;
    localparam int STAT_PENDING_BIT = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Alarm numbers
    localparam logic [2:0] ALARM_NONE = 3'h0;
    localparam logic [2:0] ALARM_INVALID_START = 3'h1;
    localparam logic [2:0] ALARM_UNDERVOLTAGE = 3'h2;
    localparam logic [2:0] ALARM_OVERVOLTAGE = 3'h3;
    localparam logic [2:0] ALARM_OVERCURRENT = 3'h4;
    localparam logic [2:0] ALARM_STAGE = 3'h5;

    // Control input positions
    localparam int IN_RUN = 0;
    localparam int IN_DIR = 1;
    localparam int IN_SPEED = 2;
    localparam logic [2:0] INPUTS_IDLE = 3'h7;

    typedef enum logic [2:0] {
        MDS_POWERUP, MDS_INVALID_START, MDS_SLEEP, MDS_ACQUIRE,
        MDS_RUN, MDS_STOP_DELAY, MDS_FAULT
    } mds_state_type;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } mds_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mds_axi_rsp_type;

    typedef struct packed {
        logic undervoltage;
        logic overvoltage;
        logic over_max_power;
        logic over_stall;
        logic motor_short;
        logic output_stage_fault;
    } mds_fault_type;

    typedef struct packed {
        logic motor_enable;
        logic motor_reverse;
        logic speed_set;
        logic sleep;
        logic acquire_request;
    } mds_drive_type;
endpackage : mds_pkg

// ### verif/mds_pin_model.sv
// Purpose: Contacts and indicator load around the supervisor.
// Assumes: Open contacts and the idle load float to the pull-up level.
// Notes: Chatter flips the run contact to mimic bounce.
`timescale 1ns/1ps
module mds_pin_model (
    // Contact commands from the bench
    input wire logic close_run,
    input wire logic close_dir,
    input wire logic close_speed,
    input wire logic chatter,
    // Pins towards the supervisor
    output logic run_stop_n,
    output logic direction_select_input,
    output logic speed_set_n,
    // Indicator transistor and its load
    input wire logic open_collector_indicator,
    input wire logic open_collector_indicator_oe_n,
    output logic indicator_line
);
    // Closed contact sinks to ground, open one floats high
    assign run_stop_n = ~(close_run ^ chatter);
    assign direction_select_input = ~close_dir;
    assign speed_set_n = ~close_speed;
    // Pull-up wins whenever the transistor is off
    assign indicator_line = open_collector_indicator_oe_n ? 1'h1
        : open_collector_indicator;
endmodule : mds_pin_model

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the motor drive supervisor.
// Assumes: Shortened times; pins come from the contact model.
// Notes: Checked ports are sampled 1 ns after an edge to let updates land; the bus tasks sample responses at the edge itself.
`timescale 1ns/1ps
module tb_top;
    import mds_pkg::*;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic close_run = 1'h0;
    logic close_dir = 1'h0;
    logic close_speed = 1'h0;
    logic chatter = 1'h0;
    logic acquisition_done = 1'h0;
    logic [7:0] current_level = 8'h00;
    mds_fault_type faults = '0;
    mds_axi_req_type axi_req = '0;
    mds_axi_rsp_type axi_rsp;
    mds_drive_type drive;
    logic [2:0] alarm_number;
    logic run_stop_n;
    logic direction_select_input;
    logic speed_set_n;
    logic oc_level;
    logic oc_oe_n;
    logic indicator_line;
    logic [31:0] rd;
    logic [1:0] resp;
    int fails = 0;
    int check_count = 0;
    int edges;
    mds_fault_type trip_f[5] = '{6'h04, 6'h08, 6'h08, 6'h02, 6'h01};
    logic [7:0] trip_lvl[5] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    int trip_lo[5] = '{8, 33, 15, 0, 0};
    int trip_hi[5] = '{16, 48, 30, 5, 5};
    logic [2:0] trip_num[5] = '{3'h4, 3'h4, 3'h4, 3'h5, 3'h5};

    always #10 clock = ~clock;

    mds_supervisor #(.POWERUP_TIME(20), .STANDBY_TIME(50), .STALL_TIME(10),
        .INVTIME_TIME(40), .DEBOUNCE_TIME(3), .BLINK_TIME(4), .PAUSE_TIME(12)
    ) i_mds_supervisor (.clock(clock), .reset(reset), .run_stop_n(run_stop_n),
        .direction_select_input(direction_select_input), .speed_set_n(speed_set_n),
        .faults(faults), .current_level(current_level), .acquisition_done(acquisition_done),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .drive(drive), .alarm_number(alarm_number),
        .open_collector_indicator(oc_level), .open_collector_indicator_oe_n(oc_oe_n));

    mds_pin_model i_mds_pin_model (.close_run(close_run), .close_dir(close_dir),
        .close_speed(close_speed), .chatter(chatter), .run_stop_n(run_stop_n),
        .direction_select_input(direction_select_input), .speed_set_n(speed_set_n),
        .open_collector_indicator(oc_level), .open_collector_indicator_oe_n(oc_oe_n),
        .indicator_line(indicator_line));

    task check(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task axi_write(input logic [7:0] addr, input logic [31:0] data);
        logic done;
        done = 1'h0;
        @(posedge clock);
        axi_req.awvalid <= 1'h1;
        axi_req.awaddr <= addr;
        axi_req.wvalid <= 1'h1;
        axi_req.wdata <= data;
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'h1;
        while (!done) begin
            @(posedge clock);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'h0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'h0;
            if (axi_rsp.bvalid === 1'h1) begin
                resp = axi_rsp.bresp;
                axi_req.bready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask : axi_write

    task axi_read(input logic [7:0] addr);
        logic done;
        done = 1'h0;
        @(posedge clock);
        axi_req.arvalid <= 1'h1;
        axi_req.araddr <= addr;
        axi_req.rready <= 1'h1;
        while (!done) begin
            @(posedge clock);
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'h0;
            if (axi_rsp.rvalid === 1'h1) begin
                rd = axi_rsp.rdata;
                resp = axi_rsp.rresp;
                axi_req.rready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask : axi_read

    task expect_status(input mds_state_type st, input logic [2:0] al);
        axi_read(ADDR_STATUS);
        check({resp, rd[6:4], rd[2:0]}, {RESP_OKAY, al, st});
    endtask : expect_status

    task boot(input logic run, input mds_fault_type f);
        @(posedge clock);
        reset <= 1'h1;
        close_run <= run;
        faults <= f;
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        tick(4);
        // Direction filter idles at reverse until the pin settles
        check(drive, 36'h8);
        expect_status(MDS_POWERUP, ALARM_NONE);
        tick(40);
    endtask : boot

    task set_run(input logic run);
        @(posedge clock);
        close_run <= run;
        tick(10);
    endtask : set_run

    task contacts(input logic dir, input logic speed, input logic bounce, input logic done);
        @(posedge clock);
        close_dir <= dir;
        close_speed <= speed;
        chatter <= bounce;
        acquisition_done <= done;
    endtask : contacts

    task count_pulses(input int span);
        logic prev;
        edges = 0;
        prev = indicator_line;
        repeat (span) begin
            tick(1);
            if (prev === 1'h1 && indicator_line === 1'h0) edges++;
            prev = indicator_line;
        end
    endtask : count_pulses

    task complete_run;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    initial begin
        #400_000;
        fails++;
        complete_run();
    end

    initial begin
        boot(1'h0, '0);
        expect_status(MDS_SLEEP, ALARM_NONE);
        axi_read(ADDR_CONTROL);
        check({resp, rd}, {RESP_OKAY, 30'h0, CONTROL_RESET});
        axi_read(8'h08);
        check({resp, rd}, {RESP_DECERR, 32'h0000_0000});
        axi_write(ADDR_STATUS, 32'hffff_ffff);
        check(resp, RESP_OKAY);
        axi_write(8'h0c, 32'h0000_0001);
        check(resp, RESP_DECERR);
        // Bounce shorter than the filter must not start the motor
        contacts(1'h0, 1'h0, 1'h1, 1'h0);
        @(posedge clock);
        contacts(1'h0, 1'h0, 1'h0, 1'h0);
        tick(10);
        expect_status(MDS_SLEEP, ALARM_NONE);
        contacts(1'h0, 1'h1, 1'h0, 1'h0);
        set_run(1'h1);
        expect_status(MDS_ACQUIRE, ALARM_NONE);
        check(drive, 36'h1d);
        contacts(1'h1, 1'h1, 1'h0, 1'h0);
        tick(10);
        check(drive, 36'h15);
        contacts(1'h1, 1'h1, 1'h0, 1'h1);
        contacts(1'h1, 1'h1, 1'h0, 1'h0);
        tick(3);
        expect_status(MDS_RUN, ALARM_NONE);
        set_run(1'h0);
        expect_status(MDS_STOP_DELAY, ALARM_NONE);
        tick(30);
        expect_status(MDS_STOP_DELAY, ALARM_NONE);
        tick(30);
        expect_status(MDS_SLEEP, ALARM_NONE);
        boot(1'h1, '0);
        expect_status(MDS_INVALID_START, ALARM_INVALID_START);
        check(drive.motor_enable, 1'h0);
        set_run(1'h0);
        expect_status(MDS_SLEEP, ALARM_NONE);
        set_run(1'h1);
        expect_status(MDS_ACQUIRE, ALARM_NONE);
        // Standby disabled: the stop delay must never end in sleep
        axi_write(ADDR_CONTROL, 32'h0000_0001);
        set_run(1'h0);
        tick(60);
        expect_status(MDS_STOP_DELAY, ALARM_NONE);
        boot(1'h0, 6'h20);
        expect_status(MDS_FAULT, ALARM_UNDERVOLTAGE);
        boot(1'h0, 6'h10);
        expect_status(MDS_FAULT, ALARM_OVERVOLTAGE);
        boot(1'h0, 6'h30);
        expect_status(MDS_FAULT, ALARM_UNDERVOLTAGE);
        boot(1'h0, '0);
        expect_status(MDS_SLEEP, ALARM_NONE);
        for (int i = 0; i < 5; i++) begin
            boot(1'h0, '0);
            set_run(1'h1);
            @(posedge clock);
            faults <= trip_f[i];
            current_level <= trip_lvl[i];
            tick(trip_lo[i]);
            check(alarm_number, ALARM_NONE);
            tick(trip_hi[i] - trip_lo[i]);
            check(alarm_number, trip_num[i]);
            check(drive.motor_enable, 1'h0);
        end
        @(posedge clock);
        faults <= 6'h20;
        tick(5);
        check(alarm_number, ALARM_STAGE);
        @(posedge clock);
        faults <= '0;
        tick(5);
        check(alarm_number, ALARM_STAGE);
        count_pulses(48);
        check(edges, 5);
        axi_write(ADDR_CONTROL, 32'h0000_0002);
        count_pulses(48);
        check({edges, indicator_line}, 1'h1);
        complete_run();
    end
endmodule : tb_top
